// >>> rtl/ptu_consts.vh
/*
 * constants for the processor trap unit: interrupt levels, dedicated
 * words, exponent width and timing counts.
 * assumes a 100 MHz processor clock and a 16-bit word.
 */
`ifndef PTU_CONSTS_VH
`define PTU_CONSTS_VH

// ----------------------------------------
// interrupt levels
// ----------------------------------------
`define PTU_LVL_POWER        5'h00
`define PTU_LVL_PARITY       5'h01
`define PTU_LVL_PROTECT      5'h02
`define PTU_LVL_FLOAT        5'h05

// ----------------------------------------
// dedicated words
// ----------------------------------------
`define PTU_WORD_PWR_RETURN  16'h0020
`define PTU_WORD_PWR_ENTRY   16'h0021

// ----------------------------------------
// widths and timing
// ----------------------------------------
`define PTU_EXP_W            9
`define PTU_CLK_MHZ          100
`define PTU_SWITCH_NS        2400
`define PTU_SWITCH_CYC       ((`PTU_SWITCH_NS * `PTU_CLK_MHZ) / 1000)
`define PTU_PF_MEM_CYCLES    200
`define PTU_SW_CNT_W         9

`endif

// >>> rtl/ptu_sync.v
/*
 * two flip-flop synchroniser for one level from outside the clock domain.
 * assumes the level is stable for several clocks.
 */
`timescale 1ns/1ps
`default_nettype none

module ptu_sync (
    // clock and reset
    input  wire ref_clk_in,
    input  wire rst_in,
    // level
    input  wire async_in,
    output reg  sync_out
);

    reg stage1;

    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            stage1   <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule // ptu_sync

`default_nettype wire

// >>> rtl/ptu_exp_norm.v
/*
 * normalisation exponent stepper: moves the result exponent one step per
 * shifted position and catches wrap past the ends.
 * assumes the float unit drives one step strobe per shifted bit.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ptu_consts.vh"

module ptu_exp_norm #(
    parameter EXP_W = `PTU_EXP_W
) (
    // clock and reset
    input  wire             ref_clk_in,
    input  wire             rst_in,
    // float unit side
    input  wire             load_in,
    input  wire [EXP_W-1:0] exp_in,
    input  wire             shift_left_in,
    input  wire             shift_right_in,
    // results
    output reg  [EXP_W-1:0] exp_out,
    output reg              underflow_out,
    output reg              overflow_out
);

    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            exp_out       <= {EXP_W{1'b0}};
            underflow_out <= 1'b0;
            overflow_out  <= 1'b0;
        end else if (load_in) begin
            exp_out       <= exp_in;
            underflow_out <= 1'b0;
            overflow_out  <= 1'b0;
        end else if (shift_left_in) begin
            exp_out <= exp_out - {{(EXP_W-1){1'b0}}, 1'b1};
            if (exp_out == {EXP_W{1'b0}}) begin
                underflow_out <= 1'b1;
            end
        end else if (shift_right_in) begin
            exp_out <= exp_out + {{(EXP_W-1){1'b0}}, 1'b1};
            if (exp_out == {EXP_W{1'b1}}) begin
                overflow_out <= 1'b1;
            end
        end
    end

endmodule // ptu_exp_norm

`default_nettype wire

// >>> rtl/ptu_trap_unit.v
/*
 * trap unit of a 16-bit processor: parity, system protect, floating
 * exponent range and power fail / auto start. raises held requests on
 * fixed levels and performs the program switch for the power level.
 * assumes the pipeline, memory and float unit are on ref_clk_in; power
 * and key switch signals are asynchronous and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ptu_consts.vh"

module ptu_trap_unit #(
    parameter PARITY_FITTED = 1,
    parameter FLOAT_FITTED  = 1,
    parameter EXP_W         = `PTU_EXP_W
) (
    // clock and reset
    input  wire             ref_clk_in,
    input  wire             rst_in,
    // pipeline and memory
    input  wire             mem_parity_err_in,
    input  wire             instr_protected_in,
    input  wire             mem_write_in,
    input  wire             target_protected_in,
    input  wire             branch_in,
    input  wire             privileged_in,
    input  wire             executive_request_instruction_in,
    input  wire [15:0]      instruction_pointer_in,
    // float unit
    input  wire             fp_load_in,
    input  wire [EXP_W-1:0] fp_exp_in,
    input  wire             fp_shift_left_in,
    input  wire             fp_shift_right_in,
    input  wire             fp_done_in,
    // asynchronous pins
    input  wire             key_protect_in,
    input  wire             power_low_in,
    input  wire             power_good_in,
    // interrupt system
    input  wire             power_level_active_in,
    input  wire             ack_parity_in,
    input  wire             ack_protect_in,
    input  wire             ack_float_in,
    // pipeline controls
    output reg              abort_out,
    output reg              write_suppress_out,
    output reg              fp_writeback_out,
    output reg              fp_terminate_out,
    output reg              halt_out,
    output reg              to_executive_out,
    // requests
    output reg              req_parity_out,
    output reg              req_protect_out,
    output reg              req_float_out,
    output reg              req_power_out,
    // program switch for the power level, then exponent range flags
    output reg              sw_busy_out,
    output reg              sw_mem_write_out,
    output reg              sw_mem_read_out,
    output reg  [15:0]      sw_addr_out,
    output reg  [15:0]      sw_data_out,
    output reg              sw_load_ip_out,
    output reg              exp_underflow_out,
    output reg              exp_overflow_out
);

    // ----------------------------------------
    // constants and helpers
    // ----------------------------------------
    localparam integer             SW_CYC_FULL = `PTU_SWITCH_CYC;
    // switch length fits the counter, upper bits are zero
    localparam [`PTU_SW_CNT_W-1:0] SW_CYC = SW_CYC_FULL[`PTU_SW_CNT_W-1:0];
    localparam [1:0] S_IDLE  = 2'h0;
    localparam [1:0] S_STORE = 2'h1;
    localparam [1:0] S_FETCH = 2'h2;
    localparam [1:0] S_WAIT  = 2'h3;

    // held request: a new event wins over the acknowledge
    function held;
        input cur;
        input set;
        input clr;
        begin
            held = set | (cur & ~clr);
        end
    endfunction

    // ----------------------------------------
    // synchronised pins
    // ----------------------------------------
    wire key_sync;
    wire plow_sync;
    wire pgood_sync;

    ptu_sync u_key (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .async_in   (key_protect_in),
        .sync_out   (key_sync)
    );
    ptu_sync u_plow (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .async_in   (power_low_in),
        .sync_out   (plow_sync)
    );
    ptu_sync u_pgood (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .async_in   (power_good_in),
        .sync_out   (pgood_sync)
    );

    // ----------------------------------------
    // exponent stepper
    // ----------------------------------------
    wire [EXP_W-1:0] exp_val;
    wire             underflow;
    wire             overflow;

    ptu_exp_norm #(.EXP_W(EXP_W)) u_exp (
        .ref_clk_in     (ref_clk_in),
        .rst_in         (rst_in),
        .load_in        (fp_load_in),
        .exp_in         (fp_exp_in),
        .shift_left_in  (fp_shift_left_in),
        .shift_right_in (fp_shift_right_in),
        .exp_out        (exp_val),
        .underflow_out  (underflow),
        .overflow_out   (overflow)
    );

    // ----------------------------------------
    // trap detection
    // ----------------------------------------
    wire checking    = key_sync & ~instr_protected_in;
    wire prot_write  = checking & mem_write_in & target_protected_in;
    wire prot_branch = checking & branch_in & target_protected_in;
    wire priv_viol   = checking & privileged_in & ~executive_request_instruction_in;
    wire prot_any    = prot_write | prot_branch | priv_viol;
    wire fp_fault    = underflow | overflow;
    wire fp_trap     = fp_done_in & fp_fault;

    reg pgood_prev;
    reg plow_prev;
    reg power_down;
    reg [1:0] sw_state;
    reg [`PTU_SW_CNT_W-1:0] sw_cnt;

    // ----------------------------------------
    // abort and write control
    // ----------------------------------------
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            abort_out          <= 1'b0;
            write_suppress_out <= 1'b0;
            fp_writeback_out   <= 1'b0;
            fp_terminate_out   <= 1'b0;
            halt_out           <= 1'b0;
            to_executive_out   <= 1'b0;
            exp_underflow_out  <= 1'b0;
            exp_overflow_out   <= 1'b0;
        end else begin
            // a branch is not aborted so the pointer keeps the target
            abort_out <= mem_parity_err_in | prot_write | priv_viol
                         | (fp_trap & (FLOAT_FITTED != 0));
            write_suppress_out <= prot_write;
            fp_writeback_out   <= fp_done_in & ~fp_fault;
            fp_terminate_out   <= fp_trap;
            to_executive_out   <= prot_any;
            exp_underflow_out  <= underflow;
            exp_overflow_out   <= overflow;
            // only master clear leaves the halt
            if (mem_parity_err_in && PARITY_FITTED == 0) begin
                halt_out <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // held requests
    // ----------------------------------------
    reg parity_pend;

    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            parity_pend     <= 1'b0;
            req_parity_out  <= 1'b0;
            req_protect_out <= 1'b0;
            req_float_out   <= 1'b0;
        end else begin
            parity_pend <= held(parity_pend, mem_parity_err_in && PARITY_FITTED != 0,
                                ack_parity_in);
            // no enable gate: level is held off only while the power level is active
            req_parity_out  <= held(parity_pend, mem_parity_err_in && PARITY_FITTED != 0,
                                    ack_parity_in) & ~power_level_active_in;
            req_protect_out <= held(req_protect_out, prot_any, ack_protect_in);
            req_float_out   <= held(req_float_out, fp_trap && FLOAT_FITTED != 0,
                                    ack_float_in);
        end
    end

    // ----------------------------------------
    // power fail / auto start
    // ----------------------------------------
    // raised the cycle after the synchronised low warning rises; the supply must give the
    // 200 memory cycle margin, this logic adds sync latency plus one register cycle
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pgood_prev    <= 1'b0;
            plow_prev     <= 1'b0;
            power_down    <= 1'b0;
            req_power_out <= 1'b0;
            sw_state      <= S_IDLE;
            sw_cnt        <= {`PTU_SW_CNT_W{1'b0}};
            sw_busy_out   <= 1'b0;
            sw_mem_write_out <= 1'b0;
            sw_mem_read_out  <= 1'b0;
            sw_addr_out   <= 16'h0000;
            sw_data_out   <= 16'h0000;
            sw_load_ip_out <= 1'b0;
        end else begin
            pgood_prev       <= pgood_sync;
            plow_prev        <= plow_sync;
            sw_mem_write_out <= 1'b0;
            sw_mem_read_out  <= 1'b0;
            sw_load_ip_out   <= 1'b0;
            // always enabled: no mask term
            if (plow_sync && !plow_prev) begin
                req_power_out <= 1'b1;
                power_down    <= 1'b1;
            end else if (pgood_sync && !pgood_prev && power_down) begin
                req_power_out <= 1'b1;
                power_down    <= 1'b0;
            end
            case (sw_state)
                S_IDLE: begin
                    sw_cnt <= {`PTU_SW_CNT_W{1'b0}};
                    if (req_power_out) begin
                        sw_busy_out <= 1'b1;
                        // auto start skips the save, nothing worth keeping
                        if (power_down) begin
                            sw_state <= S_STORE;
                        end else begin
                            sw_state <= S_FETCH;
                        end
                    end
                end
                S_STORE: begin
                    sw_mem_write_out <= 1'b1;
                    sw_addr_out      <= `PTU_WORD_PWR_RETURN;
                    sw_data_out      <= instruction_pointer_in;
                    sw_cnt           <= sw_cnt + 1'b1;
                    sw_state         <= S_FETCH;
                end
                S_FETCH: begin
                    sw_mem_read_out <= 1'b1;
                    sw_load_ip_out  <= 1'b1;
                    sw_addr_out     <= `PTU_WORD_PWR_ENTRY;
                    req_power_out   <= 1'b0;
                    sw_cnt          <= sw_cnt + 1'b1;
                    sw_state        <= S_WAIT;
                end
                S_WAIT: begin
                    sw_cnt <= sw_cnt + 1'b1;
                    if (sw_cnt >= SW_CYC - 1'b1) begin
                        sw_busy_out <= 1'b0;
                        sw_state    <= S_IDLE;
                    end
                end
                default: begin
                    sw_state <= S_IDLE;
                end
            endcase
        end
    end

endmodule // ptu_trap_unit

`default_nettype wire

// >>> verification/ptu_trap_unit_properties.sv
/*
 * checker for the trap unit: traps, held requests, float fault and power switch.
 * assumes one clock domain and a bind onto ptu_trap_unit.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ptu_consts.vh"

module ptu_trap_props (
    // clock, reset and inputs
    input wire logic        ref_clk_in, rst_in, mem_parity_err_in, instr_protected_in, mem_write_in,
    input wire logic        target_protected_in, privileged_in, executive_request_instruction_in,
    input wire logic        key_protect_in, power_level_active_in, ack_protect_in,
    // outputs
    input wire logic        abort_out, write_suppress_out, to_executive_out, req_parity_out,
    input wire logic        req_protect_out, req_float_out, fp_writeback_out, fp_terminate_out,
    input wire logic        sw_busy_out, sw_mem_write_out, sw_load_ip_out,
    input wire logic [15:0] sw_addr_out
);
    // ------------
    // helpers
    // ------------
    logic [3:0] key_hist;  // deeper than the synchroniser, so no edge case
    logic [8:0] busy_cnt;
    logic       key_on;
    logic       key_off;
    assign key_on  = &key_hist & key_protect_in & ~instr_protected_in;
    assign key_off = ~|key_hist & ~key_protect_in;
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            key_hist <= 4'h0;
            busy_cnt <= 9'h000;
        end else begin
            key_hist <= {key_hist[2:0], key_protect_in};
            busy_cnt <= sw_busy_out ? busy_cnt + 9'h001 : 9'h000;
        end
    end
    // ------------
    // properties
    // ------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    sequence ret_store_s;
        sw_mem_write_out && sw_addr_out == `PTU_WORD_PWR_RETURN;
    endsequence
    sequence entry_load_s;
        sw_load_ip_out && sw_addr_out == `PTU_WORD_PWR_ENTRY;
    endsequence
    parity_abort_a: assert property (mem_parity_err_in |=> abort_out)
        else $error("parity error did not abort");
    parity_defer_a: assert property ($past(power_level_active_in) |-> !req_parity_out)
        else $error("parity request shown under power level");
    parity_raise_a: assert property (mem_parity_err_in && !power_level_active_in |=> req_parity_out)
        else $error("parity request missing");
    prot_write_a: assert property (key_on && mem_write_in && target_protected_in
        |=> write_suppress_out && abort_out && to_executive_out) else $error("protected write not trapped");
    priv_trap_a: assert property (key_on && privileged_in && !executive_request_instruction_in
        |=> abort_out && req_protect_out && to_executive_out) else $error("privileged op not trapped");
    key_off_a: assert property (key_off |=> !write_suppress_out && !to_executive_out)
        else $error("protect trap with key off");
    req_hold_a: assert property (req_protect_out && !ack_protect_in |=> req_protect_out)
        else $error("protect request lost before ack");
    fp_fault_a: assert property (fp_terminate_out |-> abort_out && req_float_out && !fp_writeback_out)
        else $error("float fault wrote back or raised no request");
    store_entry_a: assert property (ret_store_s |-> ##[1:8] entry_load_s)
        else $error("no entry load after return store");
    switch_time_a: assert property ($fell(sw_busy_out) |-> busy_cnt == `PTU_SWITCH_CYC)
        else $error("program switch length wrong");
endmodule // ptu_trap_props

bind ptu_trap_unit ptu_trap_props i_ptu_trap_props (
    .ref_clk_in, .rst_in, .mem_parity_err_in, .instr_protected_in, .mem_write_in, .target_protected_in,
    .privileged_in, .executive_request_instruction_in, .key_protect_in, .power_level_active_in,
    .ack_protect_in, .abort_out, .write_suppress_out, .to_executive_out, .req_parity_out, .req_protect_out,
    .req_float_out, .fp_writeback_out, .fp_terminate_out, .sw_busy_out, .sw_mem_write_out, .sw_load_ip_out,
    .sw_addr_out
);
`default_nettype wire

// >>> verification/ptu_int_model.sv
/*
 * interrupt system model facing the trap unit: acks held requests after delay_in cycles.
 * assumes requests stay up until acked; the power level stays active until cleared.
 */
`timescale 1ns/1ps
`default_nettype none

module ptu_int_model (
    // clock, reset and bench controls
    input  wire logic       ref_clk_in, rst_in, clear_power_in,
    input  wire logic [3:0] delay_in,
    // requests from the trap unit
    input  wire logic       req_parity_in, req_protect_in, req_float_in, req_power_in,
    // answers: parity, protect, float
    output var  logic [2:0] ack_out,
    output var  logic       power_active_out
);
    logic [3:0] wait_cnt;
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wait_cnt         <= 4'h0;
            ack_out          <= 3'h0;
            power_active_out <= 1'b0;
        end else begin
            ack_out <= 3'h0;
            if (req_power_in)
                power_active_out <= 1'b1;
            else if (clear_power_in)
                power_active_out <= 1'b0;
            // one ack per wait, highest first; parity queues behind power
            if (!(req_parity_in | req_protect_in | req_float_in) || ack_out != 3'h0)
                wait_cnt <= 4'h0;
            else if (wait_cnt != delay_in)
                wait_cnt <= wait_cnt + 4'h1;
            else if (req_parity_in && !power_active_out)
                ack_out <= 3'h4;
            else if (req_protect_in)
                ack_out <= 3'h2;
            else if (req_float_in)
                ack_out <= 3'h1;
        end
    end
endmodule // ptu_int_model
`default_nettype wire

// >>> verification/test_processor_trap_unit.sv
/*
 * self-checking bench for the trap unit: parity, protect, float range, power fail and auto start.
 * assumes the checker binds itself and the interrupt model sits on the far side.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ptu_consts.vh"

module test_processor_trap_unit;
    logic        ref_clk_in = 1'b0, rst_in = 1'b1, fp_load_in = 1'b0, fp_done_in = 1'b0;
    logic        fp_shift_left_in = 1'b0, fp_shift_right_in = 1'b0, key_protect_in = 1'b0;
    logic        power_low_in = 1'b0, power_good_in = 1'b0, clear_power = 1'b0;
    logic [6:0]  op = 7'h00;  // instr prot, exec req, priv, branch, target prot, write, parity
    logic [8:0]  fp_exp_in = 9'h000;
    logic [15:0] instruction_pointer_in = 16'h0000;
    logic [3:0]  delay = 4'h2;
    logic [2:0]  ack;
    logic        power_level_active_in, abort_out, write_suppress_out, fp_writeback_out, fp_terminate_out;
    logic        halt_out, to_executive_out, req_parity_out, req_protect_out, req_float_out, req_power_out;
    logic        sw_busy_out, sw_mem_write_out, sw_mem_read_out, sw_load_ip_out;
    logic        exp_underflow_out, exp_overflow_out;
    logic [15:0] sw_addr_out, sw_data_out;
    int          n_fail = 0, checked = 0, i, n, w, l, p;

    always #5 ref_clk_in = ~ref_clk_in;

    ptu_trap_unit i_ptu_trap_unit (
        .ref_clk_in, .rst_in, .mem_parity_err_in(op[0]), .mem_write_in(op[1]), .target_protected_in(op[2]),
        .branch_in(op[3]), .privileged_in(op[4]), .executive_request_instruction_in(op[5]),
        .instr_protected_in(op[6]), .instruction_pointer_in, .fp_load_in, .fp_exp_in, .fp_shift_left_in,
        .fp_shift_right_in, .fp_done_in, .key_protect_in, .power_low_in, .power_good_in,
        .power_level_active_in, .ack_parity_in(ack[2]), .ack_protect_in(ack[1]), .ack_float_in(ack[0]),
        .abort_out, .write_suppress_out, .fp_writeback_out, .fp_terminate_out, .halt_out, .to_executive_out,
        .req_parity_out, .req_protect_out, .req_float_out, .req_power_out, .sw_busy_out, .sw_mem_write_out,
        .sw_mem_read_out, .sw_addr_out, .sw_data_out, .sw_load_ip_out, .exp_underflow_out, .exp_overflow_out
    );
    ptu_int_model i_ptu_int_model (
        .ref_clk_in, .rst_in, .clear_power_in(clear_power), .delay_in(delay), .req_parity_in(req_parity_out),
        .req_protect_in(req_protect_out), .req_float_in(req_float_out), .req_power_in(req_power_out),
        .ack_out(ack), .power_active_out(power_level_active_in)
    );

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic op_pulse(input logic [6:0] v);
        @(posedge ref_clk_in) op <= v;
        @(posedge ref_clk_in) op <= 7'h00;
        #1;
    endtask

    // expect {abort, suppress, executive, protect request}
    task automatic prot(input logic [6:0] v, input logic [3:0] e);
        op_pulse(v);
        chk_val("protect", {12'h000, e}, {12'h000, abort_out, write_suppress_out, to_executive_out, req_protect_out});
        repeat (8) @(posedge ref_clk_in);
    endtask

    // expect {overflow, underflow, terminate, writeback, float request, abort}
    task automatic fp_run(input logic [8:0] e, input logic left, input int steps, input logic [5:0] r);
        @(posedge ref_clk_in) fp_load_in <= 1'b1;
        fp_exp_in <= e;
        @(posedge ref_clk_in) fp_load_in <= 1'b0;
        fp_shift_left_in  <= left;
        fp_shift_right_in <= ~left;
        repeat (steps) @(posedge ref_clk_in);
        fp_shift_left_in  <= 1'b0;
        fp_shift_right_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        fp_done_in <= 1'b1;
        @(posedge ref_clk_in) fp_done_in <= 1'b0;
        #1;
        chk_val("float", {10'h000, r}, {10'h000, exp_overflow_out, exp_underflow_out, fp_terminate_out,
                fp_writeback_out, req_float_out, abort_out});
        repeat (8) @(posedge ref_clk_in);
    endtask

    task automatic sw_watch(input logic [15:0] stores);
        n = 0;
        w = 0;
        l = 0;
        p = 0;
        for (i = 0; i < 400; i++) begin
            @(posedge ref_clk_in) #1;
            if (sw_busy_out)
                n++;
            if (req_power_out)
                p++;
            if (sw_mem_write_out) begin
                w++;
                chk_val("return_word", `PTU_WORD_PWR_RETURN, sw_addr_out);
                chk_val("saved_pointer", instruction_pointer_in, sw_data_out);
            end
            if (sw_load_ip_out) begin
                l++;
                chk_val("entry_word", `PTU_WORD_PWR_ENTRY, sw_addr_out);
                chk_val("entry_read", 16'h0001, {15'h0000, sw_mem_read_out});
            end
        end
        chk_val("busy_cycles", 16'(`PTU_SWITCH_CYC), n[15:0]);
        chk_val("stores", stores, w[15:0]);
        chk_val("entries", 16'h0001, l[15:0]);
        chk_val("power_req", 16'h0001, {15'h0000, p != 0});
    endtask

    initial begin
        repeat (12) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        @(posedge ref_clk_in) #1;
        chk_val("idle", 16'h0000, {12'h000, abort_out, halt_out, req_power_out, sw_busy_out});
        op_pulse(7'h01);
        chk_val("parity", 16'h0006, {13'h0000, abort_out, req_parity_out, halt_out});
        repeat (8) @(posedge ref_clk_in);
        prot(7'h06, 4'h0);
        prot(7'h10, 4'h0);
        key_protect_in <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        prot(7'h06, 4'hf);
        prot(7'h0c, 4'h3);
        prot(7'h10, 4'hb);
        prot(7'h30, 4'h0);
        prot(7'h46, 4'h0);
        prot(7'h4c, 4'h0);
        prot(7'h02, 4'h0);
        delay <= 4'h9;
        prot(7'h10, 4'hb);
        #1;
        chk_val("req_held", 16'h0001, {15'h0000, req_protect_out});
        repeat (8) @(posedge ref_clk_in) #1;
        chk_val("req_acked", 16'h0000, {15'h0000, req_protect_out});
        @(posedge ref_clk_in) delay <= 4'h2;
        fp_run(9'h002, 1'b1, 2, 6'h04);
        fp_run(9'h001, 1'b1, 2, 6'h1b);
        fp_run(9'h1fe, 1'b0, 1, 6'h04);
        fp_run(9'h1ff, 1'b0, 1, 6'h2b);
        instruction_pointer_in <= 16'h5a3c;
        power_low_in <= 1'b1;
        sw_watch(16'h0001);
        op_pulse(7'h01);
        chk_val("parity_abort", 16'h0001, {15'h0000, abort_out});
        repeat (6) @(posedge ref_clk_in) #1;
        chk_val("parity_pending", 16'h0000, {15'h0000, req_parity_out});
        @(posedge ref_clk_in) clear_power <= 1'b1;
        @(posedge ref_clk_in) clear_power <= 1'b0;
        for (i = 0; i < 10 && req_parity_out !== 1'b1; i++)
            @(posedge ref_clk_in) #1;
        chk_val("parity_late", 16'h0001, {15'h0000, req_parity_out});
        if (req_parity_out !== 1'b1)
            stop_test;
        @(posedge ref_clk_in) power_low_in <= 1'b0;
        power_good_in <= 1'b1;
        sw_watch(16'h0000);
        stop_test;
    end
endmodule // test_processor_trap_unit
`default_nettype wire
